// >>> core/runtime_archive_pkg.sv
// Purpose: Shared constants and types for the start-up and run-time archive block
// Assumes: 250 MHz system clock, one-second time base derived by a divider
// Notes:   All timing figures are kept in their own unit and converted here
package runtime_archive_pkg;

    // Stage and archive populations and widths
    localparam int NUM_STAGES = 4;
    localparam int STAGE_W    = 2;
    localparam int ARCH_DAYS  = 32;
    localparam int DAY_W      = 5;

    // Time base
    localparam longint CLK_HZ             = 250_000_000;
    localparam int     BASE_TICK_S        = 1;
    localparam int     SEC_CYCLES_DEFAULT = int'(CLK_HZ * BASE_TICK_S);
    localparam int     ACCUM_PERIOD_S     = 30;
    localparam int     NV_SAVE_MIN        = 30;
    localparam int     SEC_PER_MIN        = 60;
    localparam int     NV_SAVE_TICKS      = NV_SAVE_MIN * SEC_PER_MIN / ACCUM_PERIOD_S;
    localparam int     SEC_PER_HOUR       = 3600;
    localparam int     SYNC_SETTLE        = 3;

    // Hour totals, display split and activity scale
    localparam int HOURS_MAX  = 29999;
    localparam int DISP_MOD   = 10000;
    localparam int PCT_SCALE  = 100;

    typedef logic [14:0] hours_t;
    typedef logic [16:0] dsec_t;
    typedef logic [15:0] cnt_t;
    typedef logic [6:0]  pct_t;

    typedef struct packed {
        dsec_t run_sp1;
        dsec_t run_sp2;
        cnt_t  starts_sp1;
        cnt_t  starts_sp2;
    } day_stage_t;

    typedef struct packed {
        logic [31:0]                   stamp;
        pct_t                          act_sp1;
        pct_t                          act_sp2;
        pct_t                          act_tot;
        day_stage_t [NUM_STAGES-1:0]   stage;
    } day_rec_t;

    typedef struct packed {
        logic first_start;
        logic use_backup;
        logic clear_archives;
        logic clear_working;
    } start_cmd_t;

    typedef struct packed {
        logic [13:0] value;
        logic [1:0]  flash_led;
    } disp_t;

    typedef enum logic [2:0] {
        ST_SETTLE    = 3'b000,
        ST_DECIDE    = 3'b001,
        ST_FIRST_DEF = 3'b010,
        ST_FIRST_BAK = 3'b011,
        ST_RESTART   = 3'b100,
        ST_RUN       = 3'b101
    } start_state_t;

endpackage : runtime_archive_pkg

// >>> core/stage_hours.sv
// Purpose: Operating-hour total of one compressor or fan stage
// Assumes: sec_tick and tick30 are one-cycle enables, tick30 coincides with a sec_tick
// Notes:   Seconds are gathered between ticks and folded into the total every 30 s
`timescale 1ns/10ps
`default_nettype none
module stage_hours
    import runtime_archive_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // Control
    input  wire logic   clear,
    input  wire logic   load,
    input  wire hours_t load_val,
    input  wire logic   sec_tick,
    input  wire logic   tick30,
    input  wire logic   running,
    // Total
    output hours_t      hours_q
);

    logic [4:0]  pend_q;
    logic [11:0] frac_q;
    wire  logic [12:0] frac_sum = {1'b0, frac_q} + 13'(pend_q);
    wire  logic        hour_done = frac_sum >= 13'(SEC_PER_HOUR);
    wire  logic        sec_on    = running & sec_tick;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_q  <= '0;
            frac_q  <= '0;
            hours_q <= '0;
        end else if (clear) begin
            pend_q  <= '0;
            frac_q  <= '0;
            hours_q <= '0;
        end else if (load) begin
            pend_q  <= '0;
            frac_q  <= '0;
            hours_q <= load_val;
        end else if (tick30) begin
            // fold the last 30 s into the hour total
            pend_q <= {4'h0, sec_on};
            if (hour_done) begin
                frac_q <= 12'(frac_sum - 13'(SEC_PER_HOUR));
                // Saturate instead of wrapping past the top of the counter
                if (hours_q != '1) begin
                    hours_q <= hours_q + 15'h1;
                end
            end else begin
                frac_q <= frac_sum[11:0];
            end
        end else if (sec_on) begin
            pend_q <= pend_q + 5'h1;
        end
    end

endmodule : stage_hours
`default_nettype wire

// >>> core/runtime_archive_startup.sv
// Purpose: Start-up decision, operating-hour totals and daily archive of a pack controller
// Assumes: Time-of-day, date stamp and power-up flags come from logic on clk
// Notes:   Keys, stage feedback and the setpoint input are pins and are synchronised
`timescale 1ns/10ps
`default_nettype none
module runtime_archive_startup
    import runtime_archive_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEFAULT
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Power-up conditions
    input  wire logic                   never_started,
    input  wire logic                   fw_updated,
    input  wire logic                   cfg_changed,
    input  wire logic                   param_ok,
    input  wire logic                   backup_valid,
    input  wire logic                   load_defaults_cmd,
    // Operator key pins
    input  wire logic                   escape_reset_key,
    input  wire logic                   up_key,
    input  wire logic                   down_key,
    // Stage and setpoint pins
    input  wire logic [NUM_STAGES-1:0]  stage_on_pin,
    input  wire logic                   sp2_pin,
    input  wire logic                   sp2_active_high,
    input  wire logic                   week_timer_sp2,
    // Time of day
    input  wire logic                   day_rollover,
    input  wire logic [31:0]            date_stamp,
    input  wire dsec_t                  sec_of_day,
    // Hour total and archive access
    input  wire logic                   hours_clear,
    input  wire logic                   hours_load,
    input  wire logic [STAGE_W-1:0]     hours_stage,
    input  wire hours_t                 hours_val,
    input  wire logic [STAGE_W-1:0]     disp_stage,
    input  wire logic [DAY_W-1:0]       arch_day,
    // Start-up results
    output start_cmd_t                  start_cmd_q,
    output logic                        running_q,
    output logic                        sp2_q,
    // Hour totals
    output logic                        nv_write_q,
    output hours_t [NUM_STAGES-1:0]     nv_hours_q,
    output disp_t                       disp_q,
    // Daily data
    output day_rec_t                    today_q,
    output logic [4:0]                  today_hours_q,
    output logic [5:0]                  today_min_q,
    output day_rec_t                    arch_q,
    output logic                        arch_valid_q
);

    function automatic disp_t split_hours(input hours_t h);
        disp_t r;
        r.flash_led = 2'h0;
        r.value     = 14'(h);
        for (int k = 3; k >= 1; k--) begin
            if (r.flash_led == 2'h0 && h >= 15'(k * DISP_MOD)) begin
                r.flash_led = 2'(k);
                r.value     = 14'(h - 15'(k * DISP_MOD));
            end
        end
        return r;
    endfunction : split_hours

    function automatic logic [18:0] sum_run(input day_stage_t [NUM_STAGES-1:0] d,
                                            input logic second);
        logic [18:0] s;
        s = '0;
        for (int k = 0; k < NUM_STAGES; k++) begin
            s = s + 19'(second ? d[k].run_sp2 : d[k].run_sp1);
        end
        return s;
    endfunction : sum_run

    function automatic pct_t activity(input logic [18:0] run, input dsec_t elapsed);
        logic [25:0] num;
        logic [25:0] den;
        logic [25:0] q;
        num = 26'(run) * 26'(PCT_SCALE);
        den = 26'(elapsed) * 26'(NUM_STAGES);
        q   = (den == '0) ? '0 : num / den;
        return (q > 26'(PCT_SCALE)) ? 7'(PCT_SCALE) : 7'(q);
    endfunction : activity

    // Pin synchronisers
    localparam int PIN_W = NUM_STAGES + 4;
    logic [PIN_W-1:0] meta_q;
    logic [PIN_W-1:0] sync_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {escape_reset_key, up_key, down_key, sp2_pin, stage_on_pin};
            sync_q <= meta_q;
        end
    end
    wire logic [NUM_STAGES-1:0] stage_s  = sync_q[NUM_STAGES-1:0];
    wire logic                  sp2_s    = sync_q[NUM_STAGES];
    wire logic                  keys_all = &sync_q[PIN_W-1:NUM_STAGES+1];

    // Start-up sequencing
    start_state_t state_q;
    start_state_t state_d;
    logic [1:0]   settle_q;
    wire logic defaults_req = never_started | fw_updated | cfg_changed | keys_all;
    wire logic run       = state_q == ST_RUN;
    wire logic first_st  = state_q == ST_FIRST_DEF || state_q == ST_FIRST_BAK;
    wire logic restart_st = state_q == ST_RESTART;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_SETTLE:    if (settle_q == 2'(SYNC_SETTLE - 1)) state_d = ST_DECIDE;
            ST_DECIDE: begin
                if (defaults_req) state_d = ST_FIRST_DEF;
                else if (!param_ok) state_d = backup_valid ? ST_FIRST_BAK : ST_FIRST_DEF;
                else state_d = ST_RESTART;
            end
            ST_FIRST_DEF: state_d = ST_RUN;
            ST_FIRST_BAK: state_d = ST_RUN;
            ST_RESTART:   state_d = ST_RUN;
            ST_RUN:       if (load_defaults_cmd) state_d = ST_FIRST_DEF;
            default:      state_d = ST_SETTLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_SETTLE;
            settle_q    <= '0;
            start_cmd_q <= '0;
            running_q   <= 1'b0;
        end else begin
            state_q     <= state_d;
            settle_q    <= settle_q + 2'h1;
            start_cmd_q <= '{first_start:    first_st,
                             use_backup:     state_q == ST_FIRST_BAK,
                             clear_archives: first_st,
                             clear_working:  first_st | restart_st};
            running_q   <= run;
        end
    end

    // Second setpoint select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sp2_q <= 1'b0;
        else     sp2_q <= week_timer_sp2 | (sp2_s == sp2_active_high);
    end

    // One-second base, 30 s fold and 30 min save
    logic [27:0] sec_cnt_q;
    logic [4:0]  cnt30_q;
    logic [5:0]  nv_cnt_q;
    wire logic sec_tick = run && sec_cnt_q == 28'(SEC_CYCLES - 1);
    wire logic tick30   = sec_tick && cnt30_q == 5'(ACCUM_PERIOD_S - 1);
    wire logic nv_due   = tick30 && nv_cnt_q == 6'(NV_SAVE_TICKS - 1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sec_cnt_q  <= '0;
            cnt30_q    <= '0;
            nv_cnt_q   <= '0;
            nv_write_q <= 1'b0;
        end else begin
            sec_cnt_q  <= (!run || sec_tick) ? '0 : sec_cnt_q + 28'h1;
            if (sec_tick) cnt30_q <= tick30 ? '0 : cnt30_q + 5'h1;
            if (tick30)   nv_cnt_q <= nv_due ? '0 : nv_cnt_q + 6'h1;
            nv_write_q <= nv_due;
        end
    end

    // Hour totals per stage
    hours_t [NUM_STAGES-1:0] hours_w;
    wire logic   load_ok  = run & hours_load;
    wire hours_t load_val = (hours_val > 15'(HOURS_MAX)) ? 15'(HOURS_MAX) : hours_val;
    for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stage
        wire logic sel = hours_stage == STAGE_W'(g);
        stage_hours u_hours (
            .clk      (clk),
            .rst      (rst),
            .clear    (first_st | (run & hours_clear & sel)),
            .load     (load_ok & sel),
            .load_val (load_val),
            .sec_tick (sec_tick),
            .tick30   (tick30),
            .running  (stage_s[g]),
            .hours_q  (hours_w[g])
        );
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nv_hours_q <= '0;
            disp_q     <= '0;
        end else begin
            if (nv_due) nv_hours_q <= hours_w;
            disp_q <= split_hours(hours_w[disp_stage]);
        end
    end

    // Daily accumulators
    day_stage_t [NUM_STAGES-1:0] day_q;
    logic [NUM_STAGES-1:0]       prev_q;
    wire logic [NUM_STAGES-1:0]  rise    = stage_s & ~prev_q;
    wire logic                   roll    = run & day_rollover;
    wire logic                   clr_day = first_st | restart_st | roll;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            day_q  <= '0;
            prev_q <= '0;
        end else begin
            prev_q <= stage_s;
            if (clr_day) begin
                day_q <= '0;
            end else if (run) begin
                for (int k = 0; k < NUM_STAGES; k++) begin
                    if (sec_tick && stage_s[k]) begin
                        if (sp2_q) day_q[k].run_sp2 <= day_q[k].run_sp2 + 17'h1;
                        else       day_q[k].run_sp1 <= day_q[k].run_sp1 + 17'h1;
                    end
                    if (rise[k]) begin
                        if (sp2_q) day_q[k].starts_sp2 <= day_q[k].starts_sp2 + 16'h1;
                        else       day_q[k].starts_sp1 <= day_q[k].starts_sp1 + 16'h1;
                    end
                end
            end
        end
    end

    // Live daily record with activity
    wire logic [18:0] run1 = sum_run(day_q, 1'b0);
    wire logic [18:0] run2 = sum_run(day_q, 1'b1);
    day_rec_t today_w;
    assign today_w = '{stamp:   date_stamp,
                       act_sp1: activity(run1, sec_of_day),
                       act_sp2: activity(run2, sec_of_day),
                       act_tot: activity(19'(run1 + run2), sec_of_day),
                       stage:   day_q};
    wire dsec_t sel_run = day_q[disp_stage].run_sp1 + day_q[disp_stage].run_sp2;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            today_q       <= '0;
            today_hours_q <= '0;
            today_min_q   <= '0;
        end else begin
            today_q       <= today_w;
            today_hours_q <= 5'(sel_run / 17'(SEC_PER_HOUR));
            today_min_q   <= 6'((sel_run % 17'(SEC_PER_HOUR)) / 17'(SEC_PER_MIN));
        end
    end

    // Archive ring of the most recent days
    day_rec_t               arch_mem [ARCH_DAYS];
    logic [DAY_W-1:0]       wr_ptr_q;
    logic [ARCH_DAYS-1:0]   valid_q;
    wire logic [DAY_W-1:0]  rd_idx = wr_ptr_q - 5'h1 - arch_day;
    always_ff @(posedge clk) begin
        if (roll) arch_mem[wr_ptr_q] <= today_w;
    end
    // No reset: ring state sits in fail-safe memory and must survive a restart
    always_ff @(posedge clk) begin
        if (first_st) begin
            wr_ptr_q <= '0;
            valid_q  <= '0;
        end else if (roll) begin
            wr_ptr_q          <= wr_ptr_q + 5'h1;
            valid_q[wr_ptr_q] <= 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arch_q       <= '0;
            arch_valid_q <= 1'b0;
        end else begin
            arch_q       <= arch_mem[rd_idx];
            arch_valid_q <= valid_q[rd_idx];
        end
    end

    // Checks
    sequence s_decide_defaults;
        state_q == ST_DECIDE && defaults_req;
    endsequence
    sequence s_decide_corrupt;
        state_q == ST_DECIDE && !defaults_req && !param_ok && backup_valid;
    endsequence

    property p_first_def;
        @(posedge clk) disable iff (rst)
        s_decide_defaults |=> ##1 start_cmd_q.first_start && !start_cmd_q.use_backup;
    endproperty
    a_first_def: assert property (p_first_def) else $error("no default first start");
    property p_backup;
        @(posedge clk) disable iff (rst)
        s_decide_corrupt |=> ##1 start_cmd_q.first_start && start_cmd_q.use_backup;
    endproperty
    a_backup: assert property (p_backup) else $error("backup set not used");
    property p_first_clears;
        @(posedge clk) disable iff (rst)
        start_cmd_q.first_start |-> valid_q == '0 && start_cmd_q.clear_archives;
    endproperty
    a_first_clears: assert property (p_first_clears) else $error("archive kept");
    property p_restart;
        @(posedge clk) disable iff (rst)
        state_q == ST_DECIDE && !defaults_req && param_ok
            |=> ##1 !start_cmd_q.first_start && start_cmd_q.clear_working;
    endproperty
    a_restart: assert property (p_restart) else $error("bad restart");
    property p_nv_save;
        @(posedge clk) disable iff (rst)
        nv_due |=> nv_write_q && nv_hours_q == $past(hours_w);
    endproperty
    a_nv_save: assert property (p_nv_save) else $error("totals not saved");
    property p_display;
        @(posedge clk) disable iff (rst)
        ##1 disp_q == split_hours($past(hours_w[disp_stage])) && disp_q.value < 14'(DISP_MOD);
    endproperty
    a_display: assert property (p_display) else $error("display split wrong");
    property p_preset;
        @(posedge clk) disable iff (rst)
        load_ok && !first_st && !hours_clear && hours_val > 15'(HOURS_MAX)
            |=> hours_w[$past(hours_stage)] == 15'(HOURS_MAX);
    endproperty
    a_preset: assert property (p_preset) else $error("preset not clamped");
    property p_rollover;
        @(posedge clk) disable iff (rst)
        roll && !first_st |=> day_q == '0 && valid_q[$past(wr_ptr_q)];
    endproperty
    a_rollover: assert property (p_rollover) else $error("rollover not archived");
    property p_sp2;
        @(posedge clk) disable iff (rst)
        !$past(rst) |-> sp2_q == ($past(week_timer_sp2) || $past(sp2_s) == $past(sp2_active_high));
    endproperty
    a_sp2: assert property (p_sp2) else $error("second setpoint select wrong");
    property p_start_count;
        @(posedge clk) disable iff (rst)
        run && rise[0] && !sp2_q && !clr_day
            |=> day_q[0].starts_sp1 == $past(day_q[0].starts_sp1) + 16'h1;
    endproperty
    a_start_count: assert property (p_start_count) else $error("start not counted");
    property p_activity;
        @(posedge clk) disable iff (rst)
        ##1 today_q.act_tot <= 7'(PCT_SCALE) && today_q.act_sp1 <= today_q.act_tot + 7'h1;
    endproperty
    a_activity: assert property (p_activity) else $error("activity out of range");

endmodule : runtime_archive_startup
`default_nettype wire

// >>> test/panel_terminal.sv
// Purpose: Operator keys and external terminal at the controller's far side
// Assumes: Bench clock, one terminal request at a time
// Notes:   Released stage and value lines carry the inverse of the last value; clear and load drop to 0
`timescale 1ns/10ps
`default_nettype none
module panel_terminal
    import runtime_archive_pkg::*;
(
    // Clock
    input  wire logic               clk,
    // Operator keys
    output var logic                escape_reset_key,
    output var logic                up_key,
    output var logic                down_key,
    // Terminal hour access
    output var logic                hours_clear,
    output var logic                hours_load,
    output var logic [STAGE_W-1:0]  hours_stage,
    output var hours_t              hours_val
);
    initial begin
        {escape_reset_key, up_key, down_key, hours_clear, hours_load} = '0;
        hours_stage = '0;
        hours_val = '0;
    end
    // The three keys only ever move together
    task automatic hold_keys(input logic h);
        escape_reset_key <= h;
        up_key <= h;
        down_key <= h;
    endtask : hold_keys
    // One-cycle request, so a stale value is never mistaken for a new one
    task automatic send(input logic clr, input logic [STAGE_W-1:0] s, input hours_t v);
        @(posedge clk);
        hours_clear <= clr;
        hours_load <= ~clr;
        hours_stage <= s;
        hours_val <= v;
        @(posedge clk);
        hours_clear <= 1'b0;
        hours_load <= 1'b0;
        hours_stage <= ~s;
        hours_val <= ~v;
    endtask : send
endmodule : panel_terminal
`default_nettype wire

// >>> test/tb_runtime_archive_startup.sv
// Purpose: Self-checking bench for start-up, hour totals and daily archive
// Assumes: Second tick shortened to 10 cycles
// Notes:   Activity is checked only at its cap and at zero, since run seconds drift by tick phase
`timescale 1ns/10ps
`default_nettype none
module tb_runtime_archive_startup;
    import runtime_archive_pkg::*;
    localparam logic [31:0] STAMP = 32'h0012_A5C3;
    logic clk, rst, never_started, fw_updated, cfg_changed, param_ok, backup_valid;
    logic sp2_pin, sp2_active_high, week_timer_sp2, day_rollover;
    logic escape_reset_key, up_key, down_key, hours_clear, hours_load, running_q;
    logic sp2_q, nv_write_q, arch_valid_q, load_defaults_cmd;
    logic [4:0] today_hours_q;
    logic [5:0] today_min_q;
    logic [NUM_STAGES-1:0] stage_on_pin;
    logic [31:0] date_stamp;
    dsec_t sec_of_day;
    logic [STAGE_W-1:0] disp_stage, hours_stage;
    hours_t hours_val;
    hours_t [NUM_STAGES-1:0] nv_hours_q;
    start_cmd_t start_cmd_q;
    disp_t disp_q;
    day_rec_t today_q, arch_q;
    int err_total, checked, nv_seen;

    runtime_archive_startup #(.SEC_CYCLES(10)) u_runtime_archive_startup (.clk, .rst,
        .never_started, .fw_updated, .cfg_changed, .param_ok, .backup_valid,
        .load_defaults_cmd, .escape_reset_key, .up_key, .down_key, .stage_on_pin,
        .sp2_pin, .sp2_active_high, .week_timer_sp2, .day_rollover, .date_stamp, .sec_of_day,
        .hours_clear, .hours_load, .hours_stage, .hours_val, .disp_stage, .arch_day(5'h00),
        .start_cmd_q, .running_q, .sp2_q, .nv_write_q, .nv_hours_q, .disp_q, .today_q,
        .today_hours_q, .today_min_q, .arch_q, .arch_valid_q);
    panel_terminal u_panel_terminal (.clk, .escape_reset_key, .up_key, .down_key,
        .hours_clear, .hours_load, .hours_stage, .hours_val);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("counts: checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // Bits: never, firmware, config, param_ok, backup, keys
    task automatic power_up(input logic [5:0] c, output int n);
        @(posedge clk);
        rst <= 1'b1;
        {never_started, fw_updated, cfg_changed, param_ok, backup_valid} <= c[5:1];
        u_panel_terminal.hold_keys(c[0]);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (start_cmd_q === '0 && n < 20);
        u_panel_terminal.hold_keys(1'b0);
    endtask : power_up
    task automatic test_start;
        logic [5:0] cfg [7] = '{6'h26, 6'h16, 6'h0E, 6'h07, 6'h02, 6'h00, 6'h06};
        logic [1:0] exp [7] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h0};
        int n;
        for (int i = 0; i < 7; i++) begin
            power_up(cfg[i], n);
            chk(n, 5, "start edge");
            chk({start_cmd_q.first_start, start_cmd_q.use_backup}, exp[i], "kind");
            chk(start_cmd_q.clear_archives, exp[i][1], "archive clear");
            if (exp[i] == 2'h0) chk(start_cmd_q.clear_working, 1, "restart");
        end
        // Parameter-triggered first start from RUN
        @(posedge clk);
        load_defaults_cmd <= 1'b1;
        @(posedge clk);
        load_defaults_cmd <= 1'b0;
        @(posedge clk);
        #1;
        chk({start_cmd_q.first_start, start_cmd_q.use_backup}, 2'h2, "param start");
        chk(start_cmd_q.clear_archives, 1, "param clear");
        $display("test start done");
    endtask : test_start
    task automatic set_hours(input logic c, input logic [1:0] s, input hours_t v,
                             input logic [31:0] ev, input logic [31:0] el);
        disp_stage <= s;
        u_panel_terminal.send(c, s, v);
        repeat (3) @(posedge clk);
        #1;
        chk(disp_q.value, ev, "disp value");
        chk(disp_q.flash_led, el, "flash led");
    endtask : set_hours
    task automatic test_hours;
        set_hours(1'b0, 2'h1, 15'h558C, 1900, 2);
        set_hours(1'b0, 2'h2, 15'h7530, 9999, 2);
        set_hours(1'b0, 2'h3, 15'h270F, 9999, 0);
        set_hours(1'b0, 2'h2, 15'h2710, 0, 1);
        set_hours(1'b1, 2'h1, 15'h0000, 0, 0);
        chk(running_q, 1, "running");
        $display("test hours done");
    endtask : test_hours
    task automatic test_run;
        set_hours(1'b1, 2'h0, 15'h0000, 0, 0);
        stage_on_pin <= 4'h1;
        repeat (37000) begin @(posedge clk); #1; if (nv_write_q === 1'b1) nv_seen++; end
        chk(nv_seen, 2, "nv writes");
        chk(disp_q.value, 1, "hours");
        chk(nv_hours_q[2], 10000, "nv total");
        chk(today_hours_q, 1, "day hours");
        chk(today_min_q, 1, "day minutes");
        chk(today_q.stage[0].run_sp1 >= 3690, 1, "day run");
        chk(today_q.stage[0].run_sp2, 0, "day run sp2");
        chk(today_q.stage[0].starts_sp1, 1, "starts");
        chk(today_q.act_tot, 100, "act total");
        chk(today_q.act_sp2, 0, "act sp2");
        $display("test run done");
    endtask : test_run
    task automatic test_sp2;
        for (int i = 0; i < 8; i++) begin
            {sp2_pin, sp2_active_high, week_timer_sp2} <= i[2:0];
            repeat (6) @(posedge clk);
            #1;
            chk(sp2_q, (i[2] == i[1]) | i[0], "sp2");
        end
        stage_on_pin <= 4'h3;
        repeat (50) @(posedge clk);
        #1;
        chk(today_q.stage[1].starts_sp2, 1, "starts sp2");
        chk(today_q.stage[1].run_sp2 >= 4, 1, "run sp2");
        $display("test sp2 done");
    endtask : test_sp2
    task automatic test_roll;
        int n;
        stage_on_pin <= 4'h0;
        repeat (20) @(posedge clk);
        day_rollover <= 1'b1;
        @(posedge clk);
        day_rollover <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(today_q.stage[0].run_sp1, 0, "zeroed");
        chk(arch_valid_q, 1, "arch valid");
        chk(arch_q.stamp, STAMP, "stamp");
        chk(arch_q.stage[0].starts_sp1, 1, "arch starts");
        chk(arch_q.stage[1].starts_sp2, 1, "arch starts sp2");
        chk(arch_q.act_tot, 100, "arch act");
        power_up(6'h06, n);
        repeat (3) @(posedge clk);
        #1;
        chk(arch_valid_q, 1, "kept");
        power_up(6'h26, n);
        repeat (3) @(posedge clk);
        #1;
        chk(arch_valid_q, 0, "cleared");
        $display("test roll done");
    endtask : test_roll

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst, never_started, fw_updated, cfg_changed, param_ok, backup_valid} = 6'h24;
        {sp2_pin, sp2_active_high, week_timer_sp2, day_rollover} = 4'h4;
        err_total = 0;
        checked = 0;
        nv_seen = 0;
        load_defaults_cmd = 1'b0;
        stage_on_pin = 4'h0;
        date_stamp = STAMP;
        sec_of_day = 17'h00001;
        disp_stage = 2'h0;
        repeat (16) @(posedge clk);
        test_start();
        test_hours();
        test_run();
        test_sp2();
        test_roll();
        complete_run();
    end
    // Whole run is near 37400 cycles
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
endmodule : tb_runtime_archive_startup
`default_nettype wire
